// ---- tas_pkg.sv ----
// shared constants and types for the test access switch
package tas_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int unsigned DATA_W = 8;
  localparam int unsigned USER_W = 4;
  localparam int unsigned PORT_W = 8;
  localparam int unsigned LFSR_W = 15;

  // ---------------------------------------------------------------
  // signal codes and reset values
  // ---------------------------------------------------------------
  // idle code value is arbitrary
  localparam logic [DATA_W-1:0] IDLE_CODE = 8'h17;
  localparam logic [DATA_W-1:0] AIS_CODE = 8'hff;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
  localparam logic [LFSR_W-1:0] LFSR_SEED = 15'h7fff;
  localparam logic [PORT_W-1:0] PORT_RST = 8'h00;
  localparam logic [PORT_W-1:0] PORT_PAIR_STEP = 8'h01;
  localparam logic [USER_W-1:0] USER_RST = 4'h0;

  // ---------------------------------------------------------------
  // enumerations
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_ACTIVE = 2'b01
  } tas_state_t;

  typedef enum logic [2:0] {
    MODE_NONE                     = 3'h0,
    MODE_SPLIT_SECOND_END_MODE    = 3'h1,
    MODE_SPLIT_BOTH_ENDS_MODE     = 3'h2,
    MODE_LOOPBACK_FIRST_END_MODE  = 3'h3,
    MODE_LOOPBACK_SECOND_END_MODE = 3'h4
  } tas_mode_t;

  typedef enum logic [1:0] {
    OP_CREATE                  = 2'h0,
    OP_REMOVE_TEST_SESSION_CMD = 2'h1,
    OP_RELEASE_LOOPBACK_CMD    = 2'h2
  } tas_op_t;

  typedef enum logic [1:0] {
    RATE_DS1  = 2'h0,
    RATE_VT15 = 2'h1,
    RATE_STS1 = 2'h2
  } tas_rate_t;

  typedef enum logic [1:0] {
    CONN_IDLE    = 2'h0,
    CONN_ONE_WAY = 2'h1,
    CONN_TWO_WAY = 2'h2
  } tas_conn_t;

  typedef enum logic [1:0] {
    PACK_DS1                  = 2'h0,
    PACK_DS3                  = 2'h1,
    PACK_SONET_INTERFACE_PACK = 2'h2
  } tas_pack_t;

  typedef enum logic [1:0] {
    SUB_PATTERN = 2'h0,
    SUB_IDLE    = 2'h1,
    SUB_AIS     = 2'h2
  } tas_sub_t;

  // a port may carry this rate only on a suitable pack
  function automatic logic tas_pack_ok(tas_rate_t r, tas_pack_t p);
    tas_pack_ok = (r == RATE_DS1) || (p == PACK_SONET_INTERFACE_PACK);
  endfunction

endpackage

// ---- tas_sub_gen.sv ----
// test pattern, idle and ais word generator
`timescale 1ns/1ps
`default_nettype none
module tas_sub_gen
  import tas_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // substitute word
  tas_sub_if.gen sub
);

  typedef struct packed {
    logic [LFSR_W-1:0] lfsr;
    logic [DATA_W-1:0] word;
  } tas_gen_t;

  tas_gen_t g_q;
  tas_gen_t g_d;
  logic [LFSR_W-1:0] nxt;

  // ---------------------------------------------------------------
  // pseudo-random source, eight bits per clock
  // ---------------------------------------------------------------
  always_comb begin
    g_d = g_q;
    nxt = g_q.lfsr;
    for (int i = 0; i < DATA_W; i++) begin
      nxt = {nxt[LFSR_W-2:0], nxt[LFSR_W-1] ^ nxt[LFSR_W-2]};
    end
    g_d.lfsr = nxt;
    case (sub.sel)
      SUB_PATTERN: g_d.word = nxt[DATA_W-1:0];
      SUB_IDLE: g_d.word = IDLE_CODE;
      SUB_AIS: g_d.word = AIS_CODE;
      default: g_d.word = IDLE_CODE;
    endcase
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      g_q <= '{lfsr: LFSR_SEED, word: IDLE_CODE};
    end else begin
      g_q <= g_d;
    end
  end

  assign sub.word = g_q.word;

endmodule
`default_nettype wire

// ---- tas_sub_if.sv ----
// substitute signal carrier between switch and generator
`timescale 1ns/1ps
`default_nettype none
interface tas_sub_if;
  import tas_pkg::*;
  tas_sub_t sel;
  logic [DATA_W-1:0] word;
  modport gen (input sel, output word);
  modport use_side (output sel, input word);
endinterface
`default_nettype wire

// ---- tas_switch.sv ----
// test access split and loopback switch for one cross-connection
`timescale 1ns/1ps
`default_nettype none
module tas_switch
  import tas_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // session command
  input wire logic cmd_valid_i,
  input wire tas_op_t cmd_op_i,
  input wire tas_mode_t cmd_mode_i,
  input wire tas_rate_t cmd_rate_i,
  input wire logic cmd_link_assoc_i,
  input wire logic [USER_W-1:0] cmd_user_i,
  input wire logic [PORT_W-1:0] cmd_test_port_i,
  output logic cmd_ack_o,
  output logic cmd_reject_o,
  // user log-off
  input wire logic logoff_valid_i,
  input wire logic [USER_W-1:0] logoff_user_i,
  // provisioning of the tested connection
  input wire tas_conn_t conn_type_i,
  input wire logic second_idle_i,
  input wire tas_pack_t first_pack_i,
  input wire tas_pack_t second_pack_i,
  input wire tas_pack_t test_pack_i,
  input wire logic pattern_src_i,
  // session status
  output logic session_active_o,
  output tas_mode_t session_mode_o,
  output logic [PORT_W-1:0] test_port1_o,
  output logic [PORT_W-1:0] test_port2_o,
  // traffic inputs
  input wire logic [DATA_W-1:0] first_in_i,
  input wire logic [DATA_W-1:0] second_in_i,
  input wire logic [DATA_W-1:0] te1_in_i,
  input wire logic [DATA_W-1:0] te2_in_i,
  // traffic outputs
  output logic [DATA_W-1:0] first_out_o,
  output logic [DATA_W-1:0] second_out_o,
  output logic [DATA_W-1:0] first_bridge_out_o,
  output logic [DATA_W-1:0] second_bridge_out_o,
  output logic [DATA_W-1:0] te1_out_o,
  output logic [DATA_W-1:0] te2_out_o
);

  typedef struct packed {
    tas_state_t st;
    tas_mode_t mode;
    tas_rate_t rate;
    tas_sub_t sub;
    logic link;
    logic [USER_W-1:0] user;
    logic [PORT_W-1:0] port1;
    logic [PORT_W-1:0] port2;
    logic ack;
    logic rej;
    logic [DATA_W-1:0] first_out;
    logic [DATA_W-1:0] second_out;
    logic [DATA_W-1:0] first_br;
    logic [DATA_W-1:0] second_br;
    logic [DATA_W-1:0] te1_out;
    logic [DATA_W-1:0] te2_out;
  } tas_sw_t;

  tas_sw_t s_q;
  tas_sw_t s_d;
  logic active;
  logic legal;
  logic is_loop;
  tas_sub_t sub_kind;

  tas_sub_if sub ();

  tas_sub_gen u_gen (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .sub(sub)
  );

  // ---------------------------------------------------------------
  // session admission
  // ---------------------------------------------------------------
  always_comb begin
    legal = 1'b1;
    case (cmd_mode_i)
      MODE_SPLIT_SECOND_END_MODE: legal = (conn_type_i == CONN_TWO_WAY);
      MODE_SPLIT_BOTH_ENDS_MODE:
        legal = (conn_type_i == CONN_TWO_WAY) &&
                cmd_test_port_i[0];
      MODE_LOOPBACK_FIRST_END_MODE: legal = 1'b1;
      MODE_LOOPBACK_SECOND_END_MODE: legal = (conn_type_i == CONN_TWO_WAY);
      default: legal = 1'b0;
    endcase
    if (!tas_pack_ok(cmd_rate_i, first_pack_i) ||
        !tas_pack_ok(cmd_rate_i, second_pack_i) ||
        !tas_pack_ok(cmd_rate_i, test_pack_i)) begin
      legal = 1'b0;
    end
  end

  // substitute kind chosen at creation
  always_comb begin
    if (cmd_rate_i != RATE_DS1) begin
      sub_kind = SUB_AIS;
    end else if (pattern_src_i &&
                 first_pack_i != PACK_SONET_INTERFACE_PACK &&
                 second_pack_i != PACK_SONET_INTERFACE_PACK) begin
      sub_kind = SUB_PATTERN;
    end else begin
      sub_kind = SUB_IDLE;
    end
  end

  assign is_loop = (s_q.mode == MODE_LOOPBACK_FIRST_END_MODE) ||
                   (s_q.mode == MODE_LOOPBACK_SECOND_END_MODE);

  // ---------------------------------------------------------------
  // session state and traffic routing
  // ---------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.ack = 1'b0;
    s_d.rej = 1'b0;
    active = (s_q.st == ST_ACTIVE);
    if (logoff_valid_i && active && s_q.link &&
        logoff_user_i == s_q.user) begin
      active = 1'b0;
    end
    if (cmd_valid_i) begin
      case (cmd_op_i)
        OP_CREATE: begin
          if (active || !legal) begin
            s_d.rej = 1'b1;
          end else begin
            active = 1'b1;
            s_d.ack = 1'b1;
            s_d.mode = cmd_mode_i;
            s_d.rate = cmd_rate_i;
            s_d.sub = sub_kind;
            s_d.link = cmd_link_assoc_i;
            s_d.user = cmd_user_i;
            s_d.port1 = cmd_test_port_i;
            if (cmd_mode_i == MODE_SPLIT_BOTH_ENDS_MODE) begin
              s_d.port2 = cmd_test_port_i + PORT_PAIR_STEP;
            end else begin
              s_d.port2 = PORT_RST;
            end
          end
        end
        OP_REMOVE_TEST_SESSION_CMD: begin
          if (active && !is_loop) begin
            active = 1'b0;
            s_d.ack = 1'b1;
          end else begin
            s_d.rej = 1'b1;
          end
        end
        OP_RELEASE_LOOPBACK_CMD: begin
          if (active && is_loop) begin
            active = 1'b0;
            s_d.ack = 1'b1;
          end else begin
            s_d.rej = 1'b1;
          end
        end
        default: s_d.rej = 1'b1;
      endcase
    end
    if (active) begin
      s_d.st = ST_ACTIVE;
    end else begin
      s_d.st = ST_IDLE;
      s_d.mode = MODE_NONE;
    end

    // normal cross-connection paths
    s_d.second_out = (conn_type_i == CONN_IDLE) ? IDLE_CODE : first_in_i;
    s_d.first_out = (conn_type_i == CONN_TWO_WAY) ? second_in_i : IDLE_CODE;
    s_d.first_br = first_in_i;
    s_d.second_br = second_in_i;
    s_d.te1_out = IDLE_CODE;
    s_d.te2_out = IDLE_CODE;
    if (s_q.st == ST_ACTIVE) begin
      case (s_q.mode)
        MODE_SPLIT_SECOND_END_MODE: begin
          s_d.te1_out = second_in_i;
          s_d.second_out = te1_in_i;
          if (!second_idle_i) begin
            s_d.first_out = sub.word;
            s_d.second_br = sub.word;
          end
        end
        MODE_SPLIT_BOTH_ENDS_MODE: begin
          s_d.te1_out = first_in_i;
          s_d.second_out = te1_in_i;
          s_d.te2_out = second_in_i;
          s_d.first_out = te2_in_i;
        end
        MODE_LOOPBACK_FIRST_END_MODE: begin
          s_d.first_out = first_in_i;
          s_d.te1_out = first_in_i;
          s_d.second_out = sub.word;
          s_d.first_br = sub.word;
        end
        MODE_LOOPBACK_SECOND_END_MODE: begin
          s_d.second_out = second_in_i;
          s_d.te1_out = second_in_i;
          s_d.first_out = sub.word;
          s_d.second_br = sub.word;
        end
        default: s_d.te1_out = IDLE_CODE;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_q <= '{st: ST_IDLE, mode: MODE_NONE, rate: RATE_DS1,
               sub: SUB_IDLE, link: 1'b0, user: USER_RST,
               port1: PORT_RST, port2: PORT_RST, ack: 1'b0, rej: 1'b0,
               first_out: DATA_RST, second_out: DATA_RST,
               first_br: DATA_RST, second_br: DATA_RST,
               te1_out: DATA_RST, te2_out: DATA_RST};
    end else begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign sub.sel = (s_q.st == ST_ACTIVE) ? s_q.sub : SUB_IDLE;
  assign cmd_ack_o = s_q.ack;
  assign cmd_reject_o = s_q.rej;
  assign session_active_o = (s_q.st == ST_ACTIVE);
  assign session_mode_o = s_q.mode;
  assign test_port1_o = s_q.port1;
  assign test_port2_o = s_q.port2;
  assign first_out_o = s_q.first_out;
  assign second_out_o = s_q.second_out;
  assign first_bridge_out_o = s_q.first_br;
  assign second_bridge_out_o = s_q.second_br;
  assign te1_out_o = s_q.te1_out;
  assign te2_out_o = s_q.te2_out;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  a_split_second_route: assert property (
    (session_active_o && s_q.mode == MODE_SPLIT_SECOND_END_MODE)
    |=> te1_out_o == $past(second_in_i) && second_out_o == $past(te1_in_i))
    else $error("split second end routing wrong");
  a_split_second_subst: assert property (
    (session_active_o && s_q.mode == MODE_SPLIT_SECOND_END_MODE &&
     !second_idle_i)
    |=> first_out_o == $past(sub.word) &&
        second_bridge_out_o == $past(sub.word))
    else $error("split second end substitution missing");
  a_split_second_bridge: assert property (
    (session_active_o && s_q.mode == MODE_SPLIT_SECOND_END_MODE)
    |=> first_bridge_out_o == $past(first_in_i))
    else $error("first end bridge disturbed");
  a_ds1_idle_kind: assert property (
    (cmd_valid_i && cmd_op_i == OP_CREATE && cmd_rate_i == RATE_DS1 &&
     !pattern_src_i) ##1 cmd_ack_o
    |-> sub.sel == SUB_IDLE)
    else $error("ds1 without source not idle");
  a_sonet_ais_kind: assert property (
    (session_active_o && s_q.rate != RATE_DS1) |-> sub.sel == SUB_AIS)
    else $error("vt or sts substitute is not ais");
  a_split_both_route: assert property (
    (session_active_o && s_q.mode == MODE_SPLIT_BOTH_ENDS_MODE)
    |=> te2_out_o == $past(second_in_i) && first_out_o == $past(te2_in_i)
        && te1_out_o == $past(first_in_i))
    else $error("split both ends routing wrong");
  a_pair_port: assert property (
    (session_active_o && s_q.mode == MODE_SPLIT_BOTH_ENDS_MODE)
    |-> test_port1_o[0] && test_port2_o == test_port1_o + PORT_PAIR_STEP)
    else $error("test port pair wrong");
  a_both_needs_two_way: assert property (
    (cmd_valid_i && cmd_op_i == OP_CREATE &&
     cmd_mode_i == MODE_SPLIT_BOTH_ENDS_MODE && conn_type_i != CONN_TWO_WAY)
    |=> cmd_reject_o && !cmd_ack_o)
    else $error("split both ends accepted off two-way");
  a_pack_restrict: assert property (
    (cmd_valid_i && cmd_op_i == OP_CREATE && cmd_rate_i != RATE_DS1 &&
     test_pack_i != PACK_SONET_INTERFACE_PACK) |=> cmd_reject_o)
    else $error("sonet rate accepted on wrong pack");
  a_loop_first_route: assert property (
    (session_active_o && s_q.mode == MODE_LOOPBACK_FIRST_END_MODE)
    |=> first_out_o == $past(first_in_i) && te1_out_o == $past(first_in_i))
    else $error("first end loopback wrong");
  a_loop_first_subst: assert property (
    (session_active_o && s_q.mode == MODE_LOOPBACK_FIRST_END_MODE)
    |=> second_out_o == $past(sub.word))
    else $error("first end loopback substitution missing");
  a_loop_second_route: assert property (
    (session_active_o && s_q.mode == MODE_LOOPBACK_SECOND_END_MODE)
    |=> second_out_o == $past(second_in_i) &&
        first_out_o == $past(sub.word))
    else $error("second end loopback wrong");
  a_logoff_teardown: assert property (
    (logoff_valid_i && session_active_o && s_q.link &&
     logoff_user_i == s_q.user && !cmd_valid_i) |=> !session_active_o)
    else $error("link session survived log-off");
  a_unlinked_persist: assert property (
    (session_active_o && !s_q.link && !cmd_valid_i) |=> session_active_o)
    else $error("unlinked session dropped");
  a_restore_paths: assert property (
    (!session_active_o && conn_type_i == CONN_TWO_WAY)
    |=> second_out_o == $past(first_in_i) &&
        first_out_o == $past(second_in_i) && te1_out_o == IDLE_CODE)
    else $error("normal paths not restored");
endmodule
`default_nettype wire

// ---- tas_switch_tb_top.sv ----
// self-checking testbench of the test access switch
`timescale 1ns/1ps
`default_nettype none
module tas_switch_tb_top;
  import tas_pkg::*;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic cmd_valid = 1'b0;
  tas_op_t cmd_op = OP_CREATE;
  tas_mode_t cmd_mode = MODE_NONE;
  tas_rate_t cmd_rate = RATE_DS1;
  logic cmd_link = 1'b0;
  logic [3:0] cmd_user = 4'h5;
  logic [7:0] cmd_port = 8'h01;
  logic logoff_valid = 1'b0;
  logic [3:0] logoff_user = 4'h0;
  tas_conn_t conn = CONN_TWO_WAY;
  logic second_idle = 1'b0;
  tas_pack_t pack = PACK_DS1;
  logic pat_src = 1'b0;
  logic [7:0] first_in = 8'h31;
  logic [7:0] second_in = 8'h42;
  logic ack, rej, active;
  tas_mode_t mode;
  logic [7:0] tp1, tp2, te1_in, te2_in, te1_out, te2_out;
  logic [7:0] first_out, second_out, fb_out, sb_out;
  int err_total = 0;
  int samples_checked = 0;
  int cycles = 0;
  tas_rate_t rt_tab [3] = '{RATE_DS1, RATE_VT15, RATE_STS1};
  logic [7:0] sub_tab [3] = '{IDLE_CODE, AIS_CODE, AIS_CODE};

  always #5 clk_i = ~clk_i;

  tas_switch u_dut (
    .clk_i(clk_i), .arst_n_i(arst_n_i),
    .cmd_valid_i(cmd_valid), .cmd_op_i(cmd_op), .cmd_mode_i(cmd_mode),
    .cmd_rate_i(cmd_rate), .cmd_link_assoc_i(cmd_link),
    .cmd_user_i(cmd_user), .cmd_test_port_i(cmd_port),
    .cmd_ack_o(ack), .cmd_reject_o(rej),
    .logoff_valid_i(logoff_valid), .logoff_user_i(logoff_user),
    .conn_type_i(conn), .second_idle_i(second_idle),
    .first_pack_i(pack), .second_pack_i(pack), .test_pack_i(pack),
    .pattern_src_i(pat_src), .session_active_o(active),
    .session_mode_o(mode), .test_port1_o(tp1), .test_port2_o(tp2),
    .first_in_i(first_in), .second_in_i(second_in),
    .te1_in_i(te1_in), .te2_in_i(te2_in),
    .first_out_o(first_out), .second_out_o(second_out),
    .first_bridge_out_o(fb_out), .second_bridge_out_o(sb_out),
    .te1_out_o(te1_out), .te2_out_o(te2_out)
  );

  tas_te_model u_te (
    .te1_out_i(te1_out), .te2_out_i(te2_out),
    .te1_in_o(te1_in), .te2_in_o(te2_in)
  );

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // one-cycle command strobe, answer judged in the cycle after the take
  task automatic cmd(input tas_op_t op, input tas_mode_t md,
                     input tas_rate_t rt, input logic lk,
                     input logic [7:0] port, input logic exp);
    @(posedge clk_i);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_mode <= md;
    cmd_rate <= rt;
    cmd_link <= lk;
    cmd_port <= port;
    @(posedge clk_i);
    cmd_valid <= 1'b0;
    @(negedge clk_i);
    check("ack", {7'h0, ack}, {7'h0, exp});
    check("reject", {7'h0, rej}, {7'h0, !exp});
  endtask

  task automatic create(input tas_mode_t md, input tas_rate_t rt,
                        input logic lk, input logic [7:0] port,
                        input logic exp);
    cmd(OP_CREATE, md, rt, lk, port, exp);
  endtask

  task automatic remove_session(input logic exp);
    cmd(OP_REMOVE_TEST_SESSION_CMD, MODE_NONE, RATE_DS1, 1'b0, 8'h01, exp);
  endtask

  task automatic release_loop(input logic exp);
    cmd(OP_RELEASE_LOOPBACK_CMD, MODE_NONE, RATE_DS1, 1'b0, 8'h01, exp);
  endtask

  // provisioning levels change at a rising edge like every other input
  task automatic provision(input tas_conn_t c, input tas_pack_t p,
                           input logic ps, input logic si);
    @(posedge clk_i);
    conn <= c;
    pack <= p;
    pat_src <= ps;
    second_idle <= si;
  endtask

  task automatic logoff(input logic [3:0] u, input logic exp_act);
    @(posedge clk_i);
    logoff_valid <= 1'b1;
    logoff_user <= u;
    @(posedge clk_i);
    logoff_valid <= 1'b0;
    @(negedge clk_i);
    check("active after logoff", {7'h0, active}, {7'h0, exp_act});
  endtask

  task automatic settle();
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_split_second();
    create(MODE_SPLIT_SECOND_END_MODE, RATE_DS1, 1'b0, 8'h01, 1'b1);
    check("mode", 8'(mode), 8'(MODE_SPLIT_SECOND_END_MODE));
    settle();
    check("te1 out", te1_out, 8'h42);
    check("second out", second_out, 8'h42 ^ 8'h5a);
    check("first out", first_out, IDLE_CODE);
    check("second bridge", sb_out, IDLE_CODE);
    check("first bridge", fb_out, 8'h31);
    provision(CONN_TWO_WAY, PACK_DS1, 1'b0, 1'b1);
    settle();
    check("first out second idle", first_out, 8'h42);
    check("second bridge second idle", sb_out, 8'h42);
    provision(CONN_TWO_WAY, PACK_DS1, 1'b0, 1'b0);
    create(MODE_LOOPBACK_FIRST_END_MODE, RATE_DS1, 1'b0, 8'h01, 1'b0);
    release_loop(1'b0);
    remove_session(1'b1);
    settle();
    check("first out normal", first_out, 8'h42);
    check("second out normal", second_out, 8'h31);
    check("second bridge normal", sb_out, 8'h42);
  endtask

  task automatic t_split_both();
    create(MODE_SPLIT_BOTH_ENDS_MODE, RATE_DS1, 1'b0, 8'h04, 1'b0);
    provision(CONN_ONE_WAY, PACK_DS1, 1'b0, 1'b0);
    create(MODE_SPLIT_BOTH_ENDS_MODE, RATE_DS1, 1'b0, 8'h03, 1'b0);
    provision(CONN_IDLE, PACK_DS1, 1'b0, 1'b0);
    create(MODE_SPLIT_BOTH_ENDS_MODE, RATE_DS1, 1'b0, 8'h03, 1'b0);
    check("idle port second out", second_out, IDLE_CODE);
    provision(CONN_TWO_WAY, PACK_DS1, 1'b0, 1'b0);
    create(MODE_SPLIT_BOTH_ENDS_MODE, RATE_DS1, 1'b0, 8'h03, 1'b1);
    check("test port one", tp1, 8'h03);
    check("port pair", tp2, 8'h04);
    settle();
    check("te1 out", te1_out, 8'h31);
    check("second out", second_out, 8'h31 ^ 8'h5a);
    check("te2 out", te2_out, 8'h42);
    check("first out", first_out, 8'h42 ^ 8'ha5);
    remove_session(1'b1);
  endtask

  task automatic t_loop_first();
    provision(CONN_ONE_WAY, PACK_DS1, 1'b0, 1'b0);
    create(MODE_LOOPBACK_FIRST_END_MODE, RATE_DS1, 1'b0, 8'h01, 1'b1);
    settle();
    check("first out loop", first_out, 8'h31);
    check("te1 monitor", te1_out, 8'h31);
    check("second out", second_out, IDLE_CODE);
    check("first bridge", fb_out, IDLE_CODE);
    remove_session(1'b0);
    release_loop(1'b1);
    check("active", {7'h0, active}, 8'h00);
    provision(CONN_TWO_WAY, PACK_DS1, 1'b0, 1'b0);
    create(MODE_LOOPBACK_FIRST_END_MODE, RATE_DS1, 1'b0, 8'h01, 1'b1);
    settle();
    check("first out loop two-way", first_out, 8'h31);
    check("second bridge kept", sb_out, 8'h42);
    release_loop(1'b1);
  endtask

  task automatic t_loop_second();
    create(MODE_LOOPBACK_SECOND_END_MODE, RATE_VT15, 1'b0, 8'h01,
           1'b0);
    for (int i = 0; i < 3; i++) begin
      provision(CONN_TWO_WAY,
                (i == 0) ? PACK_DS1 : PACK_SONET_INTERFACE_PACK, 1'b0, 1'b0);
      create(MODE_LOOPBACK_SECOND_END_MODE, rt_tab[i], 1'b0, 8'h01,
             1'b1);
      settle();
      check("second out loop", second_out, 8'h42);
      check("te1 monitor", te1_out, 8'h42);
      check("substitute", first_out, sub_tab[i]);
      check("second bridge subst", sb_out, sub_tab[i]);
      release_loop(1'b1);
    end
    provision(CONN_TWO_WAY, PACK_DS1, 1'b1, 1'b0);
    create(MODE_LOOPBACK_SECOND_END_MODE, RATE_DS1, 1'b0, 8'h01,
           1'b1);
    settle();
    check("pattern not idle", {7'h0, first_out === IDLE_CODE}, 8'h00);
    check("pattern not ais", {7'h0, first_out === AIS_CODE}, 8'h00);
    release_loop(1'b1);
    provision(CONN_TWO_WAY, PACK_DS1, 1'b0, 1'b0);
  endtask

  task automatic t_link();
    create(MODE_SPLIT_SECOND_END_MODE, RATE_DS1, 1'b1, 8'h01, 1'b1);
    logoff(4'h3, 1'b1);
    logoff(4'h5, 1'b0);
    create(MODE_SPLIT_SECOND_END_MODE, RATE_DS1, 1'b0, 8'h01, 1'b1);
    logoff(4'h5, 1'b1);
    remove_session(1'b1);
  endtask

  // ---------------------------------------------------------------
  // main sequence and timeout
  // ---------------------------------------------------------------
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      wrap_up();
    end
  end

  initial begin
    repeat (10) @(posedge clk_i);
    arst_n_i <= 1'b1;
    // the edge that releases reset still loads reset values
    repeat (2) @(negedge clk_i);
    check("active at reset", {7'h0, active}, 8'h00);
    check("mode at reset", 8'(mode), 8'(MODE_NONE));
    check("te1 idle", te1_out, IDLE_CODE);
    check("first out after reset", first_out, 8'h42);
    t_split_second();
    t_split_both();
    t_loop_first();
    t_loop_second();
    t_link();
    wrap_up();
  end
endmodule
`default_nettype wire

// ---- tas_te_model.sv ----
// test equipment model that echoes each received word, scrambled
`timescale 1ns/1ps
`default_nettype none
module tas_te_model
  import tas_pkg::*;
(
  // words from the switch
  input wire logic [DATA_W-1:0] te1_out_i,
  input wire logic [DATA_W-1:0] te2_out_i,
  // words to the switch
  output logic [DATA_W-1:0] te1_in_o,
  output logic [DATA_W-1:0] te2_in_o
);
  // different masks so that a crossed test port shows up at once
  assign te1_in_o = te1_out_i ^ 8'h5a;
  assign te2_in_o = te2_out_i ^ 8'ha5;
endmodule
`default_nettype wire
